/* File: hdl/mtrl_pkg.sv */
package mtrl_pkg;

   // ==========================================================
   // Sizes
   localparam int MTRL_PA_W = 36;
   localparam int MTRL_ADDR_LSB = 12;
   localparam int MTRL_MASK_W = MTRL_PA_W - MTRL_ADDR_LSB;
   localparam int MTRL_NUM_VAR = 8;
   localparam int MTRL_NUM_FIX = 11;

   typedef logic [7:0] mtrl_type_t;

   // ==========================================================
   // Memory type encodings
   localparam mtrl_type_t MTRL_TYPE_UNCACHEABLE = 8'h00;
   localparam mtrl_type_t MTRL_TYPE_WRITE_COMBINING = 8'h01;
   localparam mtrl_type_t MTRL_TYPE_WRITE_THROUGH = 8'h04;
   localparam mtrl_type_t MTRL_TYPE_WP = 8'h05;
   localparam mtrl_type_t MTRL_TYPE_WRITE_BACK = 8'h06;

   // ==========================================================
   // Register indices
   localparam logic [4:0] MTRL_IDX_CAP = 5'h00;
   localparam logic [4:0] MTRL_IDX_DEF = 5'h01;
   localparam logic [4:0] MTRL_IDX_FIX_FIRST = 5'h02;
   localparam logic [4:0] MTRL_IDX_FIX_LAST = 5'h0c;
   localparam logic [4:0] MTRL_IDX_VAR_FIRST = 5'h0d;
   localparam logic [4:0] MTRL_IDX_VAR_LAST = 5'h1c;

   // ==========================================================
   // Field positions and fixed values
   localparam int MTRL_CAP_FIX_BIT = 8;
   localparam int MTRL_CAP_WRITE_COMBINING_BIT = 10;
   localparam int MTRL_DEF_FIXED_RANGES_ENABLE_BIT = 10;
   localparam int MTRL_DEF_EN_BIT = 11;
   localparam int MTRL_MASK_VALID_BIT = 11;
   localparam int MTRL_FEAT_BIT = 12;
   localparam logic [7:0] MTRL_VARIABLE_RANGE_COUNT = 8'h08;
   localparam logic MTRL_FIX_SUPPORTED = 1'b1;
   localparam logic MTRL_WRITE_COMBINING_SUPPORTED = 1'b1;
   localparam logic [63:0] MTRL_CAP_VALUE = 64'h0000_0000_0000_0508;

   // ==========================================================
   // Fixed area layout
   localparam logic [19:0] MTRL_FIX16K_START = 20'h80000;
   localparam logic [19:0] MTRL_FIX4K_START = 20'hc0000;
   localparam logic [3:0] MTRL_FIX16K_REG = 4'h1;
   localparam logic [3:0] MTRL_FIX4K_REG = 4'h3;

   // ==========================================================
   // Reset values
   localparam mtrl_type_t MTRL_DEF_TYPE_RST = 8'h00;
   localparam logic MTRL_EN_RST = 1'b0;
   localparam logic [MTRL_NUM_VAR-1:0] MTRL_VALID_RST = 8'h00;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic req;
      logic wr;
      logic [4:0] idx;
      logic [63:0] wdata;
   } mtrl_msr_req_s;

   typedef struct packed {
      logic ack;
      logic gp_fault;
      logic [63:0] rdata;
   } mtrl_msr_rsp_s;

   typedef struct packed {
      mtrl_type_t def_type;
      logic fixed_ranges_enable;
      logic en;
      logic [MTRL_NUM_FIX-1:0][63:0] fixed;
      logic [MTRL_NUM_VAR-1:0][MTRL_MASK_W-1:0] base;
      logic [MTRL_NUM_VAR-1:0][7:0] btype;
      logic [MTRL_NUM_VAR-1:0][MTRL_MASK_W-1:0] mask;
      logic [MTRL_NUM_VAR-1:0] valid;
   } mtrl_cfg_s;

   function automatic logic mtrl_type_legal(input mtrl_type_t t);
      return (t == MTRL_TYPE_UNCACHEABLE) || (t == MTRL_TYPE_WRITE_COMBINING) ||
             (t == MTRL_TYPE_WRITE_THROUGH) || (t == MTRL_TYPE_WP) || (t == MTRL_TYPE_WRITE_BACK);
   endfunction

endpackage

/* File: hdl/mtrl_resolve.sv */
`timescale 1ns/1ns
module mtrl_resolve import mtrl_pkg::*; (
   // Lookup
   input wire logic [MTRL_PA_W-1:0] addr_i,
   input wire mtrl_cfg_s cfg_i,
   output mtrl_type_t type_o
);

   // ==========================================================
   // Fixed sub-range select
   function automatic mtrl_type_t fix_type(input logic [MTRL_NUM_FIX-1:0][63:0] fx, input logic [19:0] a);
      logic [3:0] r;
      logic [2:0] b;
      begin
         if (a < MTRL_FIX16K_START) begin
            r = 4'h0;
            b = a[18:16];
         end else if (a < MTRL_FIX4K_START) begin
            r = MTRL_FIX16K_REG + {3'b000, a[17]};
            b = a[16:14];
         end else begin
            r = MTRL_FIX4K_REG + {1'b0, a[17:15]};
            b = a[14:12];
         end
         return fx[r][{b, 3'b000} +: 8];
      end
   endfunction

   // ==========================================================
   // Resolution
   always_comb begin
      logic hit;
      logic any_uncacheable;
      logic any_write_through;
      logic any_other;
      logic first_mb;
      mtrl_type_t first;
      hit = 1'b0;
      any_uncacheable = 1'b0;
      any_write_through = 1'b0;
      any_other = 1'b0;
      first = MTRL_TYPE_UNCACHEABLE;
      first_mb = (addr_i[MTRL_PA_W-1:20] == '0);
      for (int k = 0; k < MTRL_NUM_VAR; k++) begin
         if (cfg_i.valid[k] &&
             ((addr_i[MTRL_PA_W-1:MTRL_ADDR_LSB] & cfg_i.mask[k]) ==
              (cfg_i.base[k] & cfg_i.mask[k]))) begin
            if (!hit) begin
               first = cfg_i.btype[k];
            end
            hit = 1'b1;
            any_uncacheable = any_uncacheable | (cfg_i.btype[k] == MTRL_TYPE_UNCACHEABLE);
            any_write_through = any_write_through | (cfg_i.btype[k] == MTRL_TYPE_WRITE_THROUGH);
            any_other = any_other | ((cfg_i.btype[k] != MTRL_TYPE_WRITE_THROUGH) &&
                                     (cfg_i.btype[k] != MTRL_TYPE_WRITE_BACK));
         end
      end
      if (!cfg_i.en) begin
         type_o = MTRL_TYPE_UNCACHEABLE;
      end else if (cfg_i.fixed_ranges_enable && first_mb) begin
         type_o = fix_type(cfg_i.fixed, addr_i[19:0]);
      end else if (hit) begin
         // Undefined overlaps fall back to the lowest numbered range
         if (any_uncacheable) begin
            type_o = MTRL_TYPE_UNCACHEABLE;
         end else if (any_write_through && !any_other) begin
            type_o = MTRL_TYPE_WRITE_THROUGH;
         end else begin
            type_o = first;
         end
      end else begin
         type_o = cfg_i.def_type;
      end
   end

endmodule // mtrl_resolve

/* File: hdl/mtrl_unit.sv */
`timescale 1ns/1ns
// Summary of operation
// - Capability register low byte reports eight variable ranges; register is read-only.
// - Capability bit 8 shows fixed-range registers exist.
// - Capability bit 10 shows write-combining type is available.
// - Writing capability register faults; bit 9 and bits 11 up reserved.
// - Capability register always reads constant 508h.
// - Default type accepts only 0,1,4,5,6; others fault.
// - With fixed enable set, fixed types apply and beat variable ranges.
// - With fixed enable clear, variable ranges may type the first megabyte.
// - Global enable clear gives uncacheable everywhere; set gives default when unmatched.
// - Nonzero write to default bits 8, 9 or 12 up faults.
// - Eleven 64-bit fixed registers, each eight byte-wide type fields.
// - First fixed register covers 0 to 7FFFFh in 64 KB pieces.
// - Two registers cover 80000h to BFFFFh in 16 KB pieces.
// - Eight registers cover C0000h to FFFFFh in 4 KB pieces.
// - Lowest sub-range uses bits 7:0, each higher sub-range next byte.
// - Eight variable ranges, each a base register paired with a mask register.
// - Base register low byte holds the matched range's type.
// - Base field from bit 12 upward, zero extended for 4 KB alignment.
// - Address matches when address AND mask equals base AND mask.
// - Mask field is 24 bits for 36-bit addresses; upper bits reserved.
// - Mask bit 11 is the pair's valid flag.
// - Feature word bit 12 reports the mechanism is implemented.
// - Types are 00h,01h,04h,05h,06h; other encodings fault.
// - Overlapping matches: uncacheable wins, write-through beats write-back.
// - Reset clears all valid flags and the global enable.
module mtrl_unit import mtrl_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Model register read and write port
   input wire mtrl_msr_req_s msr_req_i,
   output mtrl_msr_rsp_s msr_rsp_o,
   // Memory type lookup
   input wire logic lkp_req_i,
   input wire logic [MTRL_PA_W-1:0] lkp_addr_i,
   output logic lkp_valid_o,
   output mtrl_type_t lkp_type_o,
   // Feature word
   output logic [31:0] feature_word_o
);

   typedef struct packed {
      mtrl_cfg_s cfg;
      mtrl_msr_rsp_s rsp;
      logic lkp_valid;
      mtrl_type_t lkp_type;
   } mtrl_state_s;

   mtrl_state_s st_reg;
   mtrl_state_s st_next;
   mtrl_type_t resolved;

   // ==========================================================
   // Helpers
   function automatic logic [2:0] var_slot(input logic [4:0] idx);
      logic [4:0] d;
      begin
         d = idx - MTRL_IDX_VAR_FIRST;
         return d[3:1];
      end
   endfunction

   function automatic logic var_is_mask(input logic [4:0] idx);
      logic [4:0] d;
      begin
         d = idx - MTRL_IDX_VAR_FIRST;
         return d[0];
      end
   endfunction

   function automatic logic fix_legal(input logic [63:0] v);
      logic ok;
      begin
         ok = 1'b1;
         for (int b = 0; b < 8; b++) begin
            ok = ok & mtrl_type_legal(v[8*b +: 8]);
         end
         return ok;
      end
   endfunction

   function automatic logic [63:0] cap_word();
      logic [63:0] c;
      begin
         c = '0;
         c[7:0] = MTRL_VARIABLE_RANGE_COUNT;
         c[MTRL_CAP_FIX_BIT] = MTRL_FIX_SUPPORTED;
         c[MTRL_CAP_WRITE_COMBINING_BIT] = MTRL_WRITE_COMBINING_SUPPORTED;
         return c;
      end
   endfunction

   // ==========================================================
   // Lookup path
   mtrl_resolve u_resolve (
      .addr_i(lkp_addr_i),
      .cfg_i(st_reg.cfg),
      .type_o(resolved)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic [63:0] wd;
      logic [63:0] rd;
      logic fault;
      logic [2:0] n;
      logic [3:0] f;
      st_next = st_reg;
      wd = msr_req_i.wdata;
      rd = '0;
      fault = 1'b0;
      n = var_slot(msr_req_i.idx);
      f = 4'(msr_req_i.idx - MTRL_IDX_FIX_FIRST);

      // Lookup answers on the next edge using settings before any same-cycle write
      st_next.lkp_valid = lkp_req_i;
      st_next.lkp_type = lkp_req_i ? resolved : st_reg.lkp_type;

      st_next.rsp.ack = msr_req_i.req;
      st_next.rsp.gp_fault = 1'b0;
      if (msr_req_i.req) begin
         if (msr_req_i.idx == MTRL_IDX_CAP) begin
            rd = cap_word();
            fault = msr_req_i.wr;
         end else if (msr_req_i.idx == MTRL_IDX_DEF) begin
            rd[7:0] = st_reg.cfg.def_type;
            rd[MTRL_DEF_FIXED_RANGES_ENABLE_BIT] = st_reg.cfg.fixed_ranges_enable;
            rd[MTRL_DEF_EN_BIT] = st_reg.cfg.en;
            if (msr_req_i.wr) begin
               fault = !mtrl_type_legal(wd[7:0]) ||
                       (wd[9:8] != 2'b00) || (wd[63:12] != '0);
               if (!fault) begin
                  st_next.cfg.def_type = wd[7:0];
                  st_next.cfg.fixed_ranges_enable = wd[MTRL_DEF_FIXED_RANGES_ENABLE_BIT];
                  st_next.cfg.en = wd[MTRL_DEF_EN_BIT];
               end
            end
         end else if (msr_req_i.idx <= MTRL_IDX_FIX_LAST) begin
            rd = st_reg.cfg.fixed[f];
            if (msr_req_i.wr) begin
               fault = !fix_legal(wd);
               if (!fault) begin
                  st_next.cfg.fixed[f] = wd;
               end
            end
         end else if (msr_req_i.idx <= MTRL_IDX_VAR_LAST) begin
            if (var_is_mask(msr_req_i.idx)) begin
               rd[MTRL_PA_W-1:MTRL_ADDR_LSB] = st_reg.cfg.mask[n];
               rd[MTRL_MASK_VALID_BIT] = st_reg.cfg.valid[n];
               if (msr_req_i.wr) begin
                  // Upper mask bits are reserved at 36-bit addressing
                  fault = (wd[63:MTRL_PA_W] != '0) || (wd[10:0] != '0);
                  if (!fault) begin
                     st_next.cfg.mask[n] = wd[MTRL_PA_W-1:MTRL_ADDR_LSB];
                     st_next.cfg.valid[n] = wd[MTRL_MASK_VALID_BIT];
                  end
               end
            end else begin
               rd[MTRL_PA_W-1:MTRL_ADDR_LSB] = st_reg.cfg.base[n];
               rd[7:0] = st_reg.cfg.btype[n];
               if (msr_req_i.wr) begin
                  fault = (wd[63:MTRL_PA_W] != '0) || (wd[11:8] != 4'h0) ||
                          !mtrl_type_legal(wd[7:0]);
                  if (!fault) begin
                     st_next.cfg.base[n] = wd[MTRL_PA_W-1:MTRL_ADDR_LSB];
                     st_next.cfg.btype[n] = wd[7:0];
                  end
               end
            end
         end else begin
            // Unimplemented index faults on read and write alike
            fault = 1'b1;
         end
         st_next.rsp.gp_fault = fault;
         st_next.rsp.rdata = (msr_req_i.wr || fault) ? 64'h0000_0000_0000_0000 : rd;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // Undefined-at-reset fields are cleared for determinism
         st_reg <= '0;
         st_reg.cfg.def_type <= MTRL_DEF_TYPE_RST;
         st_reg.cfg.en <= MTRL_EN_RST;
         st_reg.cfg.valid <= MTRL_VALID_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign msr_rsp_o = st_reg.rsp;
   assign lkp_valid_o = st_reg.lkp_valid;
   assign lkp_type_o = st_reg.lkp_type;
   assign feature_word_o = 32'h0000_0001 << MTRL_FEAT_BIT;

endmodule // mtrl_unit

/* File: dv/mtrl_unit_asserts.sv */
`timescale 1ns/1ns
module mtrl_unit_asserts import mtrl_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port
   input wire mtrl_msr_req_s msr_req_i,
   input wire mtrl_msr_rsp_s msr_rsp_o,
   // Lookup
   input wire logic lkp_req_i,
   input wire logic [MTRL_PA_W-1:0] lkp_addr_i,
   input wire logic lkp_valid_o,
   input wire mtrl_type_t lkp_type_o,
   input wire logic [31:0] feature_word_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   mtrl_msr_req_s q;
   mtrl_msr_rsp_s r;
   logic en_reg;
   logic en_next;
   logic def_ok;
   assign q = msr_req_i;
   assign r = msr_rsp_o;
   function automatic logic ok_t(input logic [7:0] t);
      return t inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
   endfunction
   // ==========================================
   // Shadow of the global enable, accepted writes only
   assign def_ok = ok_t(q.wdata[7:0]) && q.wdata[9:8] == 2'h0 && q.wdata[63:12] == 52'h0;
   always_comb begin
      en_next = en_reg;
      if (q.req && q.wr && q.idx == MTRL_IDX_DEF && def_ok) en_next = q.wdata[11];
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) en_reg <= 1'b0;
      else en_reg <= en_next;
   end
   // ==========================================
   // Register port
   sequence s_wr(lo, hi);
      q.req && q.wr && q.idx >= lo && q.idx <= hi;
   endsequence
   sequence s_gp;
      r.ack && r.gp_fault && r.rdata == 64'h0;
   endsequence
   a_cap_const: assert property (q.req && !q.wr && q.idx == 5'h00 |=> r.ack && !r.gp_fault && r.rdata == 64'h508)
      else $error("capability read wrong");
   a_cap_ro: assert property (s_wr(5'h00, 5'h00) |=> s_gp)
      else $error("capability write not refused");
   a_def_resv: assert property (s_wr(5'h01, 5'h01) ##0 (q.wdata[9:8] != 2'h0 || q.wdata[63:12] != 52'h0) |=> s_gp)
      else $error("reserved default bits accepted");
   a_def_type: assert property (s_wr(5'h01, 5'h01) ##0 !ok_t(q.wdata[7:0]) |=> s_gp)
      else $error("illegal default type accepted");
   a_fix_type: assert property (s_wr(5'h02, 5'h0c) ##0 !ok_t(q.wdata[7:0]) |=> s_gp)
      else $error("illegal fixed type accepted");
   a_mask_resv: assert property (s_wr(5'h0e, 5'h1c) ##0 !q.idx[0] && q.wdata[63:36] != 28'h0 |=> s_gp)
      else $error("upper mask bits accepted");
   // ==========================================
   // Lookup
   a_lkp_lat: assert property (lkp_req_i |=> lkp_valid_o)
      else $error("lookup answer late");
   a_type_hold: assert property (!lkp_req_i |=> !lkp_valid_o && $stable(lkp_type_o))
      else $error("lookup output moved without request");
   a_off_uncached: assert property (lkp_req_i && !en_reg |=> lkp_type_o == 8'h00)
      else $error("disabled unit not uncacheable");
   a_feature: assert property (feature_word_o == 32'h0000_1000)
      else $error("feature word wrong");
endmodule // mtrl_unit_asserts

bind mtrl_unit mtrl_unit_asserts u_mtrl_unit_asserts (.clk_i(clk_i), .nrst_i(nrst_i), .msr_req_i(msr_req_i),
   .msr_rsp_o(msr_rsp_o), .lkp_req_i(lkp_req_i), .lkp_addr_i(lkp_addr_i), .lkp_valid_o(lkp_valid_o),
   .lkp_type_o(lkp_type_o), .feature_word_o(feature_word_o));

/* File: dv/mtrl_core_model.sv */
`timescale 1ns/1ns
module mtrl_core_model import mtrl_pkg::*; (
   // Clock
   input wire logic clk_i,
   // Lookup request
   output logic lkp_req_o,
   output logic [MTRL_PA_W-1:0] lkp_addr_o,
   // Lookup answer
   input wire logic lkp_valid_i,
   input wire mtrl_type_t lkp_type_i
);
   initial begin
      lkp_req_o = 1'b0;
      lkp_addr_o = '0;
   end
   task automatic look(input logic [MTRL_PA_W-1:0] a, output mtrl_type_t t, output logic v);
      @(negedge clk_i);
      lkp_req_o = 1'b1;
      lkp_addr_o = a;
      @(negedge clk_i);
      v = lkp_valid_i;
      t = lkp_type_i;
      lkp_req_o = 1'b0;
      // Idle address flips so a stale value never looks right
      lkp_addr_o = ~a;
   endtask
endmodule // mtrl_core_model

/* File: dv/mtrl_unit_tb_top.sv */
`timescale 1ns/1ns
module mtrl_unit_tb_top import mtrl_pkg::*;;
   logic clk_i;
   logic nrst_i;
   mtrl_msr_req_s req;
   mtrl_msr_rsp_s rsp;
   logic lreq;
   logic [MTRL_PA_W-1:0] laddr;
   logic lval;
   mtrl_type_t ltype;
   logic [31:0] feat;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   logic [7:0] tl [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
   logic [63:0] rsv [4] = '{64'h100, 64'h200, 64'h1000, 64'h8000_0000_0000_0000};
   mtrl_unit u_mtrl_unit (.clk_i(clk_i), .nrst_i(nrst_i), .msr_req_i(req), .msr_rsp_o(rsp), .lkp_req_i(lreq),
      .lkp_addr_i(laddr), .lkp_valid_o(lval), .lkp_type_o(ltype), .feature_word_o(feat));
   mtrl_core_model u_mtrl_core_model (.clk_i(clk_i), .lkp_req_o(lreq), .lkp_addr_o(laddr), .lkp_valid_i(lval),
      .lkp_type_i(ltype));
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic msr(input logic w, input logic [4:0] i, input logic [63:0] d, output logic [65:0] res);
      @(negedge clk_i);
      req = '{1'b1, w, i, d};
      @(negedge clk_i);
      res = {rsp.ack, rsp.gp_fault, rsp.rdata};
      req.req = 1'b0;
   endtask
   task automatic wr(input logic [4:0] i, input logic [63:0] d, input logic e);
      logic [65:0] res;
      msr(1'b1, i, d, res);
      chk(res, {1'b1, e, 64'h0});
   endtask
   task automatic rd(input logic [4:0] i, input logic [63:0] x);
      logic [65:0] res;
      msr(1'b0, i, 64'h0, res);
      chk(res, {2'b10, x});
   endtask
   task automatic lk(input logic [35:0] a, input logic [7:0] x);
      mtrl_type_t t;
      logic v;
      u_mtrl_core_model.look(a, t, v);
      chk({v, t}, {1'b1, x});
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      logic [65:0] res;
      rd(MTRL_IDX_CAP, 64'h508);
      chk(feat, 32'h1000);
      rd(MTRL_IDX_DEF, 64'h0);
      rd(MTRL_IDX_VAR_FIRST + 5'h1, 64'h0);
      lk(36'h0, 8'h00);
      wr(MTRL_IDX_CAP, 64'h0, 1'b1);
      rd(MTRL_IDX_CAP, 64'h508);
      // Index past the last range pair is unmapped and faults even on read
      msr(1'b0, 5'h1d, 64'h0, res);
      chk(res, {2'b11, 64'h0});
   endtask
   task automatic t_def();
      for (int t = 0; t < 8; t++) wr(MTRL_IDX_DEF, 64'h800 | 64'(t), !(t inside {0, 1, 4, 5, 6}));
      rd(MTRL_IDX_DEF, 64'h806);
      for (int k = 0; k < 4; k++) wr(MTRL_IDX_DEF, rsv[k] | 64'h806, 1'b1);
      rd(MTRL_IDX_DEF, 64'h806);
      lk(36'h0, 8'h06);
   endtask
   task automatic t_fixed();
      logic [63:0] v;
      logic [35:0] a;
      logic [35:0] s;
      for (int r = 0; r < 11; r++) begin
         for (int b = 0; b < 8; b++) v[8*b +: 8] = tl[(3*r+b)%5];
         wr(MTRL_IDX_FIX_FIRST + 5'(r), v, 1'b0);
      end
      rd(MTRL_IDX_FIX_LAST, v);
      wr(MTRL_IDX_DEF, 64'hc06, 1'b0);
      for (int r = 0; r < 11; r++) begin
         for (int b = 0; b < 8; b++) begin
            s = r == 0 ? 36'h10000 : r < 3 ? 36'h4000 : 36'h1000;
            a = r == 0 ? 36'h0 : r < 3 ? 36'h80000 + 36'(r-1) * 36'h20000 : 36'hc0000 + 36'(r-3) * 36'h8000;
            a = a + 36'(b) * s;
            lk(a, tl[(3*r+b)%5]);
            lk(a + s - 36'h1, tl[(3*r+b)%5]);
         end
      end
   endtask
   task automatic t_var();
      wr(MTRL_IDX_VAR_FIRST, 64'h04, 1'b0);
      wr(MTRL_IDX_VAR_FIRST + 5'h1, 64'hf_ffe0_0800, 1'b0);
      lk(36'h0, 8'h00);
      lk(36'h1f_f000, 8'h04);
      lk(36'h20_0000, 8'h06);
      wr(MTRL_IDX_DEF, 64'h806, 1'b0);
      lk(36'h0, 8'h04);
      wr(MTRL_IDX_VAR_FIRST + 5'h2, 64'h06, 1'b0);
      wr(MTRL_IDX_VAR_FIRST + 5'h3, 64'hf_ffe0_0800, 1'b0);
      lk(36'h10_0000, 8'h04);
      wr(MTRL_IDX_VAR_FIRST + 5'h4, 64'h00, 1'b0);
      wr(MTRL_IDX_VAR_FIRST + 5'h5, 64'hf_ffe0_0800, 1'b0);
      lk(36'h10_0000, 8'h00);
      wr(MTRL_IDX_VAR_FIRST + 5'h5, 64'hf_ffe0_0000, 1'b0);
      lk(36'h10_0000, 8'h04);
      wr(MTRL_IDX_VAR_FIRST + 5'h6, 64'h40_0001, 1'b0);
      wr(MTRL_IDX_VAR_FIRST + 5'h7, 64'hf_ffff_f800, 1'b0);
      lk(36'h40_0fff, 8'h01);
      lk(36'h40_1000, 8'h06);
      wr(MTRL_IDX_VAR_FIRST + 5'h6, 64'h40_0101, 1'b1);
      wr(MTRL_IDX_VAR_FIRST + 5'h7, 64'h1f_ffff_f800, 1'b1);
      wr(MTRL_IDX_VAR_FIRST + 5'h6, 64'h40_0002, 1'b1);
      wr(MTRL_IDX_FIX_FIRST, 64'h07, 1'b1);
      rd(MTRL_IDX_VAR_FIRST + 5'h6, 64'h40_0001);
      wr(MTRL_IDX_DEF, 64'h406, 1'b0);
      lk(36'h1_0000, 8'h00);
   endtask
   task automatic t_rst2();
      @(negedge clk_i);
      nrst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      rd(MTRL_IDX_VAR_FIRST + 5'h1, 64'h0);
      rd(MTRL_IDX_DEF, 64'h0);
      lk(36'h40_0000, 8'h00);
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================
   // Clock, watchdog and main sequence
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      nrst_i = 1'b0;
      req = '0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      t_reset();
      t_def();
      t_fixed();
      t_var();
      t_rst2();
      conclude();
   end
endmodule // mtrl_unit_tb_top
